// ===== inc/rhpb_pkg.sv
package rhpb_pkg;

    // Register space geometry
    localparam int RHPB_ADDR_W = 12;
    localparam int RHPB_DATA_W = 32;
    localparam int RHPB_BE_W = 4;
    localparam int RHPB_NUM_PORTS = 2;
    localparam int RHPB_FIELD_W = 16;

    // Register offset
    localparam logic [RHPB_ADDR_W-1:0] RHPB_OFF_PORT_POWER_AND_REMOVABLE = 12'h04c;

    // Field positions
    localparam int RHPB_MASK_LSB = 16;
    localparam int RHPB_FLAGS_LSB = 0;

    // Reset values: ports 1 and 2 masked, all devices removable
    localparam logic [RHPB_FIELD_W-1:0] RHPB_MASK_RESET = 16'h0006;
    localparam logic [RHPB_FIELD_W-1:0] RHPB_FLAGS_RESET = 16'h0000;

    // Bit 0 of each field is reserved and held at zero
    localparam logic [RHPB_FIELD_W-1:0] RHPB_FIELD_WRITABLE = 16'hfffe;

    // Switching mode encoding
    localparam logic RHPB_MODE_GANGED = 1'b0;
    localparam logic RHPB_MODE_PER_PORT = 1'b1;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [RHPB_ADDR_W-1:0] addr;
        logic [RHPB_BE_W-1:0] be;
        logic [RHPB_DATA_W-1:0] wdata;
    } rhpb_bus_req_s;

    typedef struct packed {
        logic set_global;
        logic clr_global;
        logic [RHPB_NUM_PORTS:1] set_port;
        logic [RHPB_NUM_PORTS:1] clr_port;
    } rhpb_pwr_cmd_s;

    typedef struct packed {
        logic [RHPB_FIELD_W-1:0] port_power_mask;
        logic [RHPB_FIELD_W-1:0] fixed_device_flags;
        logic [RHPB_DATA_W-1:0] rdata;
        logic ack;
        logic hit;
        logic written;
    } rhpb_desc_state_s;

    typedef struct packed {
        logic [RHPB_NUM_PORTS:1] powered;
    } rhpb_pwr_state_s;

endpackage

// ===== design/rhpb_port_power.sv
`timescale 1ns/100ps
`default_nettype none

module rhpb_port_power (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Steering
    input wire logic per_port_switch_select,
    input wire logic [rhpb_pkg::RHPB_NUM_PORTS:1] port_mask,
    // Power commands
    input wire rhpb_pkg::rhpb_pwr_cmd_s pwr_cmd,
    // Port power state
    output logic [rhpb_pkg::RHPB_NUM_PORTS:1] port_power_on
);
    import rhpb_pkg::*;

    rhpb_pwr_state_s state_reg;
    rhpb_pwr_state_s state_next;

    // Set takes priority when set and clear arrive together
    function automatic logic apply_cmd(input logic cur, input logic set_c, input logic clr_c);
        logic r;
        r = cur;
        if (set_c) begin
            r = 1'b1;
        end else if (clr_c) begin
            r = 1'b0;
        end
        return r;
    endfunction

    always_comb begin
        state_next = state_reg;
        for (int p = 1; p <= RHPB_NUM_PORTS; p++) begin
            if (per_port_switch_select == RHPB_MODE_GANGED) begin
                // Mask ignored, all ports on the global switch
                state_next.powered[p] = apply_cmd(state_reg.powered[p], pwr_cmd.set_global,
                                                  pwr_cmd.clr_global);
            end else if (port_mask[p]) begin
                state_next.powered[p] = apply_cmd(state_reg.powered[p], pwr_cmd.set_port[p],
                                                  pwr_cmd.clr_port[p]);
            end else begin
                state_next.powered[p] = apply_cmd(state_reg.powered[p], pwr_cmd.set_global,
                                                  pwr_cmd.clr_global);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port_power_on = state_reg.powered;

endmodule

`default_nettype wire

// ===== design/rhpb_desc_b.sv
// What this block does
// - Register decoded at byte offset 0x4C
// - Reset: port 1,2 mask set, rest clear
// - Per-port mode: masked port obeys only per-port power commands
// - Unmasked port obeys only global power commands
// - Ganged mode ignores mask, all ports global
// - Mask bit 0 reserved, bits 1,2 ports
// - Lower halfword: set means non-removable device
// - Flags bit 0 reserved, bits 1,2 ports
// - Mode zero ganged, one per-port by mask
`timescale 1ns/100ps
`default_nettype none

module rhpb_desc_b (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access
    input wire rhpb_pkg::rhpb_bus_req_s bus_req,
    output logic [rhpb_pkg::RHPB_DATA_W-1:0] bus_rdata,
    output logic bus_ack,
    output logic bus_hit,
    // Switching mode from the first descriptor register
    input wire logic per_port_switch_select,
    // Power commands from the hub command logic
    input wire rhpb_pkg::rhpb_pwr_cmd_s pwr_cmd,
    // Register contents and port state
    output logic [rhpb_pkg::RHPB_FIELD_W-1:0] port_power_mask,
    output logic [rhpb_pkg::RHPB_FIELD_W-1:0] fixed_device_flags,
    output logic [rhpb_pkg::RHPB_NUM_PORTS:1] port_non_removable,
    output logic [rhpb_pkg::RHPB_NUM_PORTS:1] port_per_port_ctrl,
    output logic [rhpb_pkg::RHPB_NUM_PORTS:1] port_power_on,
    output logic desc_written
);
    import rhpb_pkg::*;

    rhpb_desc_state_s state_reg;
    rhpb_desc_state_s state_next;

    logic req_write;
    logic req_read;
    logic addr_hit;
    logic [RHPB_DATA_W-1:0] reg_value;
    logic [RHPB_DATA_W-1:0] merged;

    // Byte-lane merge of a write into an old word
    function automatic logic [RHPB_DATA_W-1:0] lane_merge(
        input logic [RHPB_DATA_W-1:0] old_v,
        input logic [RHPB_DATA_W-1:0] new_v,
        input logic [RHPB_BE_W-1:0] be
    );
        logic [RHPB_DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < RHPB_BE_W; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Clears reserved bit 0 of a field
    function automatic logic [RHPB_FIELD_W-1:0] field_clean(
        input logic [RHPB_FIELD_W-1:0] v
    );
        return v & RHPB_FIELD_WRITABLE;
    endfunction

    // Word offset match, low two address bits ignored
    function automatic logic addr_match(
        input logic [RHPB_ADDR_W-1:0] a,
        input logic [RHPB_ADDR_W-1:0] off
    );
        return a[RHPB_ADDR_W-1:2] == off[RHPB_ADDR_W-1:2];
    endfunction

    assign addr_hit = addr_match(bus_req.addr, RHPB_OFF_PORT_POWER_AND_REMOVABLE);
    assign req_write = bus_req.sel && bus_req.wr;
    assign req_read = bus_req.sel && bus_req.rd && !bus_req.wr;

    // Current register image as seen by a read
    assign reg_value = {field_clean(state_reg.port_power_mask),
                        field_clean(state_reg.fixed_device_flags)};

    assign merged = lane_merge(reg_value, bus_req.wdata, bus_req.be);

    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.written = 1'b0;
        if (req_write) begin
            state_next.ack = 1'b1;
            state_next.hit = addr_hit;
            if (addr_hit) begin
                // Upper ports keep storage only
                state_next.port_power_mask =
                    field_clean(merged[RHPB_MASK_LSB +: RHPB_FIELD_W]);
                state_next.fixed_device_flags =
                    field_clean(merged[RHPB_FLAGS_LSB +: RHPB_FIELD_W]);
                state_next.written = 1'b1;
            end
        end else if (req_read) begin
            state_next.ack = 1'b1;
            state_next.hit = addr_hit;
            if (addr_hit) begin
                state_next.rdata = reg_value;
            end else begin
                state_next.rdata = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg.port_power_mask <= RHPB_MASK_RESET;
            state_reg.fixed_device_flags <= RHPB_FLAGS_RESET;
            state_reg.rdata <= '0;
            state_reg.ack <= 1'b0;
            state_reg.hit <= 1'b0;
            state_reg.written <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata = state_reg.rdata;
    assign bus_ack = state_reg.ack;
    assign bus_hit = state_reg.hit;
    assign desc_written = state_reg.written;

    assign port_power_mask = field_clean(state_reg.port_power_mask);
    assign fixed_device_flags = field_clean(state_reg.fixed_device_flags);

    // Set flag means non-removable device on that port
    assign port_non_removable =
        state_reg.fixed_device_flags[RHPB_NUM_PORTS:1];

    // Per-port control only counts in per-port mode
    assign port_per_port_ctrl =
        (per_port_switch_select == RHPB_MODE_PER_PORT) ?
        state_reg.port_power_mask[RHPB_NUM_PORTS:1] : '0;

    rhpb_port_power u_port_power (
        .core_clk(core_clk),
        .resetn(resetn),
        .per_port_switch_select(per_port_switch_select),
        .port_mask(state_reg.port_power_mask[RHPB_NUM_PORTS:1]),
        .pwr_cmd(pwr_cmd),
        .port_power_on(port_power_on)
    );

endmodule

`default_nettype wire

// ===== verification/rhpb_desc_b_chk.sv
`timescale 1ns/100ps
`default_nettype none

module rhpb_desc_b_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access
    input wire rhpb_pkg::rhpb_bus_req_s bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic bus_hit,
    // Steering and commands
    input wire logic per_port_switch_select,
    input wire rhpb_pkg::rhpb_pwr_cmd_s pwr_cmd,
    // Register contents and port state
    input wire logic [15:0] port_power_mask,
    input wire logic [15:0] fixed_device_flags,
    input wire logic [2:1] port_non_removable,
    input wire logic [2:1] port_per_port_ctrl,
    input wire logic [2:1] port_power_on,
    input wire logic desc_written
);
    import rhpb_pkg::*;
    wire logic acc = bus_req.sel && (bus_req.wr || bus_req.rd);
    wire logic hit = bus_req.addr[11:2] == RHPB_OFF_PORT_POWER_AND_REMOVABLE[11:2];
    wire logic wrh = acc && bus_req.wr && hit;
    wire logic rdh = acc && !bus_req.wr && hit;
    wire logic [2:1] msk = port_power_mask[2:1];
    wire logic pp = per_port_switch_select;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    reset_value_a: assert property ($rose(resetn) |-> {port_power_mask, fixed_device_flags} == 32'h0006_0000) else $error("bad reset value");
    ack_pulse_a: assert property (bus_ack == $past(acc)) else $error("ack not one cycle after access");
    hit_decode_a: assert property (acc |=> bus_hit == $past(hit)) else $error("bad decode");
    read_data_a: assert property (rdh |=> bus_rdata == $past({port_power_mask, fixed_device_flags})) else $error("bad read data");
    mask_write_a: assert property (wrh && bus_req.be == 4'hf |=> port_power_mask == {$past(bus_req.wdata[31:17]), 1'b0}) else $error("bad mask write");
    flag_write_a: assert property (wrh && bus_req.be == 4'hf |=> fixed_device_flags == {$past(bus_req.wdata[15:1]), 1'b0}) else $error("bad flag write");
    removable_out_a: assert property (port_non_removable == fixed_device_flags[2:1]) else $error("bad removable");
    steer_out_a: assert property (port_per_port_ctrl == (msk & {2{pp}})) else $error("bad steering");
    ganged_on_a: assert property (!pp && pwr_cmd.set_global |=> port_power_on == 2'b11) else $error("global set lost");
    masked_hold_a: assert property (pp && msk[1] && !pwr_cmd.set_port[1] && !pwr_cmd.clr_port[1] |=> $stable(port_power_on[1])) else $error("masked port moved");
    unmasked_hold_a: assert property (pp && !msk[2] && !pwr_cmd.set_global && !pwr_cmd.clr_global |=> $stable(port_power_on[2])) else $error("unmasked port moved");
    written_pulse_a: assert property (desc_written == $past(wrh)) else $error("bad write pulse");
    masked_set_a: assert property (pp && msk[1] && pwr_cmd.set_port[1] |=> port_power_on[1]) else $error("masked port set lost");
    unmasked_set_a: assert property (pp && !msk[2] && pwr_cmd.set_global |=> port_power_on[2]) else $error("unmasked port set lost");
    cover property (wrh);
    cover property (rdh);
    cover property (pp && pwr_cmd.set_global);
endmodule

bind rhpb_desc_b rhpb_desc_b_chk u_chk (.core_clk, .resetn, .bus_req, .bus_rdata, .bus_ack,
    .bus_hit, .per_port_switch_select, .pwr_cmd, .port_power_mask, .fixed_device_flags,
    .port_non_removable, .port_per_port_ctrl, .port_power_on, .desc_written);

`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    import rhpb_pkg::*;
    localparam logic [11:0] OFF = RHPB_OFF_PORT_POWER_AND_REMOVABLE;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic mode = 1'b0;
    rhpb_bus_req_s req = '0;
    rhpb_pwr_cmd_s cmd = '0;
    logic [31:0] rdata;
    logic ack, hit, wrt;
    logic [15:0] mask, flags;
    logic [2:1] nrem, ctrl, pwr;
    int mismatches = 0;
    int n_checks = 0;

    always #25 core_clk = ~core_clk;

    rhpb_desc_b u_dut (.core_clk, .resetn, .bus_req(req), .bus_rdata(rdata), .bus_ack(ack),
        .bus_hit(hit), .per_port_switch_select(mode), .pwr_cmd(cmd), .port_power_mask(mask),
        .fixed_device_flags(flags), .port_non_removable(nrem), .port_per_port_ctrl(ctrl),
        .port_power_on(pwr), .desc_written(wrt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access, returns in the ack cycle
    task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
            input logic [31:0] d);
        @(posedge core_clk);
        #1 req = '{sel: 1'b1, wr: w, rd: !w, addr: a, be: be, wdata: d};
        @(posedge core_clk);
        #1 req = '0;
        check({hit, ack}, {a == OFF, 1'b1});
    endtask

    // Command bits: set_global, clr_global, set_port, clr_port
    task automatic pulse(input logic [5:0] c, input logic [2:1] exp);
        @(posedge core_clk);
        #1 cmd = c;
        @(posedge core_clk);
        #1 cmd = '0;
        check(pwr, exp);
    endtask

    task automatic reset_test();
        check({mask, flags}, 32'h0006_0000);
        check({pwr, wrt, ctrl}, '0);
        access(1'b0, OFF, 4'h0, '0);
        check(rdata, 32'h0006_0000);
    endtask

    task automatic field_test();
        access(1'b1, OFF, 4'hf, 32'hffff_ffff);
        check({wrt, nrem}, 3'b111);
        access(1'b0, OFF, 4'h0, '0);
        check(rdata, 32'hfffe_fffe);
        access(1'b1, OFF, 4'h5, 32'h0);
        check(nrem, 2'b00);
        access(1'b1, 12'h050, 4'hf, 32'h0);
        check(wrt, 1'b0);
        access(1'b0, 12'h050, 4'h0, '0);
        check(rdata, 32'h0);
        access(1'b0, OFF, 4'h0, '0);
        check(rdata, 32'hff00_ff00);
    endtask

    task automatic power_test();
        access(1'b1, OFF, 4'hf, 32'h0002_0000);
        mode = 1'b1;
        pulse(6'b001100, 2'b01);
        check(ctrl, 2'b01);
        pulse(6'b100000, 2'b11);
        pulse(6'b010000, 2'b01);
        pulse(6'b000011, 2'b00);
        pulse(6'b100000, 2'b10);
        pulse(6'b000011, 2'b10);
        mode = 1'b0;
        pulse(6'b001100, 2'b10);
        check(ctrl, 2'b00);
        pulse(6'b010000, 2'b00);
        pulse(6'b100000, 2'b11);
        pulse(6'b010000, 2'b00);
        pulse(6'b110000, 2'b11);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        #1 resetn = 1'b1;
        reset_test();
        field_test();
        power_test();
        end_sim();
    end

    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule

`default_nettype wire
